//--- bench/ncs_mem_model.sv
// Program ROM and data memory model facing the nibble CPU
`timescale 1ns/100ps
`default_nettype none
module ncs_mem_model
   import ncs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [ROM_AW-1:0] romAddr,
   output logic [ROM_DW-1:0]      romData,
   input  wire logic [PTR_W-1:0]  ramAddr,
   input  wire logic [NIB_W-1:0]  ramWrData,
   input  wire logic              ramWe,
   output logic [NIB_W-1:0]       ramRdData
);
   logic [NIB_W-1:0] mem [0:1023];

   // ROM word echoes its own address, so constants are predictable
   assign romData   = {3'h0, romAddr};
   assign ramRdData = mem[ramAddr];

   // Preload with low address nibble
   initial
   begin
      for (int i = 0; i < 1024; i++)
         mem[i] = i[3:0];
   end

   // Write strobe stores the nibble
   always @(posedge clk)
   begin
      if (ramWe)
         mem[ramAddr] <= ramWrData;
   end
endmodule : ncs_mem_model
`default_nettype wire

//--- bench/nibble_cpu_sequencing_datapath_bench.sv
// Register level bench for the nibble CPU sequencing datapath
`timescale 1ns/100ps
`default_nettype none
module nibble_cpu_sequencing_datapath_bench
   import ncs_pkg::*;
;
   typedef struct packed {ncs_op_t op; logic [3:0] imm; logic [3:0] acc; logic c;} ncs_step_t;

   logic              clk, rst_n, hsel, hwrite, hreadyout, hresp, ramWe;
   logic [BUS_W-1:0]  haddr, hwdata, hrdata;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic              hready;
   logic [ROM_AW-1:0] romAddr;
   logic [ROM_DW-1:0] romData;
   logic [PTR_W-1:0]  ramAddr;
   logic [NIB_W-1:0]  ramWrData, ramRdData;
   int                errors, compares;
   ncs_step_t         tbl [14] = '{'{OP_ADI, 4'h9, 4'h9, 1'b0}, '{OP_ADI, 4'h9, 4'h2, 1'b1},
      '{OP_DEC_ADJ_ADD, 4'h0, 4'h8, 1'b1}, '{OP_AND, 4'h0, 4'h0, 1'b1},
      '{OP_OR, 4'h0, 4'h5, 1'b1}, '{OP_XOR, 4'h0, 4'h0, 1'b1}, '{OP_ADC, 4'h0, 4'h6, 1'b0},
      '{OP_SHIFT_RIGHT, 4'h0, 4'h3, 1'b0}, '{OP_SBI, 4'h9, 4'hA, 1'b0},
      '{OP_DEC_ADJ_SUB, 4'h0, 4'h4, 1'b0}, '{OP_ADD, 4'h0, 4'h9, 1'b0},
      '{OP_SUB, 4'h0, 4'h4, 1'b1}, '{OP_SBC, 4'h0, 4'hF, 1'b0}, '{OP_LOAD_IND, 4'h0, 4'h5, 1'b0}};

   assign hready = hreadyout;

   ncs_core i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .romAddr(romAddr),
      .romData(romData), .ramAddr(ramAddr), .ramWrData(ramWrData), .ramWe(ramWe),
      .ramRdData(ramRdData));

   ncs_mem_model i_mem (.clk(clk), .romAddr(romAddr), .romData(romData),
      .ramAddr(ramAddr), .ramWrData(ramWrData), .ramWe(ramWe), .ramRdData(ramRdData));

   // Clock at 125 MHz
   always #4 clk = ~clk;

   task automatic summarize;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bounded wait for ready at a rising edge
   task automatic waitRdy;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         errors++;
         summarize();
      end
   endtask : waitRdy

   // One single word transfer: address phase, then data phase
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= 32'(a);
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      waitRdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask : wr

   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      xfer(1'b0, a, 32'h0, d);
      chk(nm, e, d);
   endtask : rdChk

   // Issue one instruction and poll until it has retired
   task automatic exec(input ncs_op_t op, input logic [11:0] arg, input ncs_cond_t c = COND_A0);
      logic [31:0] s;
      int          n;
      wr(OFF_CMD, 32'({arg, c, op}));
      n = 0;
      do
      begin
         xfer(1'b0, OFF_STATUS, 32'h0, s);
         n++;
      end while (s[0] !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         errors++;
         summarize();
      end
   endtask : exec

   function automatic logic [31:0] st(input logic [3:0] d, input logic [3:0] t,
                                      input logic [3:0] a, input logic c);
      return 32'({d, t, a, c, 1'b0});
   endfunction : st

   // Main sequence
   initial
   begin
      logic [7:0] tk;
      tk = 8'hA5;
      errors = 0;
      compares = 0;
      clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdChk("pc", OFF_PC, 12'h000);
      rdChk("status", OFF_STATUS, 32'h0);
      rdChk("unmapped", 8'h20, 32'h0);
      chk("hresp", 32'h0, 32'(hresp));
      chk("ready", 32'h1, 32'(hreadyout));
      $display("test reset done");
      exec(OP_UNCOND_JUMP, 12'hFFF);
      rdChk("pc", OFF_PC, 12'hFFF);
      chk("rom", 13'h0FFF, 32'(romAddr));
      wr(OFF_BANK, 32'h1);
      rdChk("bank", OFF_BANK, 32'h1);
      exec(OP_NOP, 12'h000);
      rdChk("pc", OFF_PC, 12'h800);
      chk("rom", 13'h1000, 32'(romAddr));
      wr(OFF_BANK, 32'h0);
      wr(OFF_PC, 32'h123);
      rdChk("pc", OFF_PC, 12'h800);
      $display("test paging done");
      wr(OFF_PTR, 32'h2A5);
      for (int i = 0; i < 14; i++)
      begin
         exec(tbl[i].op, 12'(tbl[i].imm));
         rdChk("alu", OFF_STATUS, st(4'h0, 4'h0, tbl[i].acc, tbl[i].c));
      end
      wr(OFF_PTR, 32'h3FF);
      rdChk("ptr", OFF_PTR, 10'h3FF);
      exec(OP_STORE_IND, 12'h000);
      chk("ramaddr", 10'h3FF, 32'(ramAddr));
      chk("ram", 4'h5, 32'(i_mem.mem[1023]));
      rdChk("data", OFF_DATA, 32'hF);
      $display("test alu done");
      for (int i = 0; i < 8; i++)
      begin
         exec(OP_UNCOND_JUMP, 12'h100);
         exec(OP_BRANCH, 12'h055, ncs_cond_t'(i));
         rdChk("branch", OFF_PC, tk[i] ? 12'h055 : 12'h101);
      end
      $display("test branch done");
      exec(OP_ADI, 12'h00F);
      exec(OP_UNCOND_JUMP, 12'h010);
      for (int k = 1; k <= 9; k++)
         exec(OP_CALL, 12'h100 + 12'(k));
      rdChk("status", OFF_STATUS, st(4'h8, 4'h0, 4'h4, 1'b1));
      exec(OP_ADI, 12'h000);
      for (int k = 9; k >= 2; k--)
      begin
         exec(OP_RETURN_INT, 12'h000);
         rdChk("ret", OFF_PC, 12'h100 + 12'(k));
      end
      rdChk("status", OFF_STATUS, st(4'h0, 4'h0, 4'h4, 1'b1));
      $display("test stack done");
      exec(OP_UNCOND_JUMP, 12'h5F0);
      exec(OP_CALL, 12'h0A7);
      exec(OP_ADI, 12'h000);
      exec(OP_RETURN_CONST, 12'h000);
      rdChk("const", OFF_STATUS, st(4'h0, 4'hA, 4'h8, 1'b0));
      rdChk("pc", OFF_PC, 12'h5F1);
      exec(OP_TABLE_JUMP, 12'h000);
      rdChk("tjump", OFF_PC, 12'h5A8);
      exec(OP_INT_ENTRY, 12'h002);
      rdChk("vector", OFF_PC, 12'h002);
      exec(OP_RETURN_INT, 12'h000);
      rdChk("pc", OFF_PC, 12'h5A8);
      $display("test table done");
      summarize();
   end
endmodule : nibble_cpu_sequencing_datapath_bench
`default_nettype wire

//--- hdl/ncs_alu.sv
// Nibble ALU: binary, decimal adjust, logic and shift operations
`timescale 1ns/100ps
`default_nettype none
module ncs_alu
   import ncs_pkg::*;
(
   input  wire ncs_op_t          op,
   input  wire logic [NIB_W-1:0] a,
   input  wire logic [NIB_W-1:0] b,
   input  wire logic             cin,
   output ncs_alu_t              res
);

   logic             isSub;
   logic             carryIn;
   logic [NIB_W-1:0] addB;
   logic [NIB_W:0]   sum;

   // Shared adder; subtraction adds the complement, carry high means no borrow
   assign isSub   = (op == OP_SUB) || (op == OP_SBC) || (op == OP_SBI);
   assign carryIn = (op == OP_ADC || op == OP_SBC) ? cin : isSub;
   assign addB    = isSub ? ~b : b;
   assign sum     = {1'b0, a} + {1'b0, addB} + (NIB_W + 1)'(carryIn);

   // Result select per operation
   always_comb
   begin
      res = '{value: a, carry: cin, carryWr: 1'b0, accWr: 1'b1};
      unique case (op)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADI, OP_SBI:
         begin
            res.value   = sum[NIB_W-1:0];
            res.carry   = sum[NIB_W];
            res.carryWr = 1'b1;
         end
         OP_DEC_ADJ_ADD:
            if (cin || a > DEC_LIMIT)
            begin
               res.value   = a + DEC_ADD;
               res.carry   = 1'b1;
               res.carryWr = 1'b1;
            end
         OP_DEC_ADJ_SUB:
            if (!cin)
               res.value = a + DEC_SUB;
         OP_AND:         res.value = a & b;
         OP_OR:          res.value = a | b;
         OP_XOR:         res.value = a ^ b;
         OP_SHIFT_RIGHT: res.value = a >> 1;
         default:        res.accWr = 1'b0;
      endcase
   end

endmodule : ncs_alu
`default_nettype wire

//--- hdl/ncs_core.sv
// Sequencer, program counter, accumulator and AHB-Lite registers of the CPU
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - PC is page bit over 11-bit counter
// - Jump can set the page bit
// - PC reaches 4K words, banks extend
// - ALU adds, subtracts, adjusts, logic, shifts
// - Carry takes arithmetic overflow or no-borrow
// - Call and interrupt push carry; interrupt return restores
// - Constant return leaves carry alone
// - Accumulator nibble holds results, moves data
// - Table jump uses PC top, TABLE_BRANCH_REG, accumulator
// - Constant return loads ROM byte halves
// - Pointer is 3+3+4 bits, ten total
// - Indirect access uses pointer bits nine-zero
// - Stack entry is carry over PC, eight
// - Returns pop the newest entry
// - Overflow drops oldest entry, no error
// - Instruction takes four clock periods
// - Upper 2K maps to bank one or two
// - Reset at zero, vectors zero to seven
module ncs_core
   import ncs_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               hsel,
   input  wire logic [BUS_W-1:0]   haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [BUS_W-1:0]   hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [BUS_W-1:0]        hrdata,
   output logic                    hresp,
   output logic [ROM_AW-1:0]       romAddr,
   input  wire logic [ROM_DW-1:0]  romData,
   output logic [PTR_W-1:0]        ramAddr,
   output logic [NIB_W-1:0]        ramWrData,
   output logic                    ramWe,
   input  wire logic [NIB_W-1:0]   ramRdData
);

   // Map CPU address to ROM: lower 2K always bank 0
   function automatic logic [ROM_AW-1:0] romMap(input logic [PC_W-1:0] pc,
                                                input logic bankSel);
      logic [1:0] hi;
      hi = !pc[PAGE_BIT] ? BANK0_HI : (bankSel ? BANK2_HI : BANK1_HI);
      return {hi, pc[LOW_W-1:0]};
   endfunction : romMap

   // Branch condition on accumulator bits, zero or carry
   function automatic logic condMet(input ncs_cond_t c, input logic [NIB_W-1:0] a,
                                    input logic cy);
      logic r;
      unique case (c)
         COND_A0:  r = a[0];
         COND_A1:  r = a[1];
         COND_A2:  r = a[2];
         COND_A3:  r = a[3];
         COND_AZ:  r = (a == '0);
         COND_ANZ: r = (a != '0);
         COND_C:   r = cy;
         COND_NC:  r = !cy;
      endcase
      return r;
   endfunction : condMet

   logic                 selWrReg;
   logic [ADDR_W-1:0]    wAddrReg;
   logic [BUS_W-1:0]     hrdataReg;
   logic                 busyReg;
   logic [1:0]           phaseReg;
   ncs_cmd_t             cmdReg;
   logic [PC_W-1:0]      pcReg, pcNext, pcInc;
   logic [NIB_W-1:0]     accReg, accNext;
   logic [NIB_W-1:0]     tbrReg, tbrNext;
   logic                 carryReg, carryNext;
   ncs_ptr_t             pointerReg;
   logic                 bankReg;
   logic [NIB_W-1:0]     ramDataReg;
   logic [ROM_DW-1:0]    romWordReg;
   logic [ROM_AW-1:0]    romAddrReg;
   logic [PTR_W-1:0]     ramAddrReg;
   logic [NIB_W-1:0]     ramWrDataReg;
   logic                 ramWeReg;
   logic                 pushReq, popReq;
   ncs_stack_t           pushData, stackTop;
   logic [DEPTH_W-1:0]   stackDepth;
   ncs_alu_t             aluRes;
   ncs_status_t          statusWord;
   ncs_const_t           constWord;

   // Bus decode: single word transfers only, zero wait states
   wire addrTake  = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
   wire wrCmd     = selWrReg && wAddrReg == OFF_CMD;
   wire wrPtr     = selWrReg && wAddrReg == OFF_PTR;
   wire wrBank    = selWrReg && wAddrReg == OFF_BANK;
   wire startCmd  = wrCmd && !busyReg;
   wire commit    = busyReg && phaseReg == PH_LAST;
   wire sample    = busyReg && phaseReg == PH_SAMPLE;
   wire [ADDR_W-1:0] rAddr = haddr[ADDR_W-1:0];
   wire [BUS_W-1:0]  rdMux =
        (rAddr == OFF_STATUS) ? BUS_W'(statusWord) :
        (rAddr == OFF_PC)     ? BUS_W'(pcReg)      :
        (rAddr == OFF_PTR)    ? BUS_W'(pointerReg) :
        (rAddr == OFF_BANK)   ? BUS_W'(bankReg)    :
        (rAddr == OFF_DATA)   ? BUS_W'(ramDataReg) : '0;

   assign statusWord = '{depth: stackDepth, table_branch_reg: tbrReg, acc: accReg,
                         carry: carryReg, busy: busyReg};
   assign constWord  = ncs_const_t'(romWordReg[CONST_W-1:0]);
   assign pcInc      = {pcReg[PAGE_BIT], LOW_W'(pcReg[LOW_W-1:0] + 1'b1)};

   // Bus phase tracking and read data
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selWrReg  <= 1'b0;
         wAddrReg  <= '0;
         hrdataReg <= '0;
      end
      else
      begin
         selWrReg  <= addrTake && hwrite;
         wAddrReg  <= rAddr;
         hrdataReg <= (addrTake && !hwrite) ? rdMux : '0;
      end
   end

   // Four-phase instruction sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busyReg  <= 1'b0;
         phaseReg <= '0;
         cmdReg   <= '0;
      end
      else if (startCmd)
      begin
         busyReg  <= 1'b1;
         phaseReg <= '0;
         cmdReg   <= ncs_cmd_t'(hwdata[CMD_W-1:0]);
      end
      else if (busyReg)
      begin
         phaseReg <= phaseReg + 1'b1;
         busyReg  <= !commit;
      end
   end

   ncs_alu u_alu (
      .op  (cmdReg.op),
      .a   (accReg),
      .b   ((cmdReg.op == OP_ADI || cmdReg.op == OP_SBI) ? cmdReg.arg[NIB_W-1:0]
                                                        : ramDataReg),
      .cin (carryReg),
      .res (aluRes)
   );

   ncs_stack u_stack (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (pushReq),
      .pop       (popReq),
      .pushEntry (pushData),
      .topEntry  (stackTop),
      .depth     (stackDepth)
   );

   // Next program counter, accumulator, table branch and carry
   always_comb
   begin
      pcNext    = pcReg;
      accNext   = accReg;
      tbrNext   = tbrReg;
      carryNext = carryReg;
      pushReq   = 1'b0;
      popReq    = 1'b0;
      pushData  = '{carry: carryReg, pc: pcInc};
      if (commit)
      begin
         pcNext = pcInc;
         if (aluRes.accWr)
            accNext = aluRes.value;
         if (aluRes.carryWr)
            carryNext = aluRes.carry;
         unique case (cmdReg.op)
            OP_LOAD_IND:    accNext = ramDataReg;
            OP_UNCOND_JUMP: pcNext = cmdReg.arg;
            OP_BRANCH:
               if (condMet(cmdReg.cond, accReg, carryReg))
                  pcNext = {pcReg[PAGE_BIT], cmdReg.arg[LOW_W-1:0]};
            OP_CALL:
            begin
               pushReq = 1'b1;
               pcNext  = cmdReg.arg;
            end
            OP_INT_ENTRY:
            begin
               pushReq     = 1'b1;
               pushData.pc = pcReg;
               pcNext      = PC_W'(cmdReg.arg[VEC_W-1:0]);
            end
            OP_RETURN_INT:
            begin
               popReq    = 1'b1;
               pcNext    = stackTop.pc;
               carryNext = stackTop.carry;
            end
            OP_RETURN_CONST:
            begin
               popReq  = 1'b1;
               pcNext  = stackTop.pc;
               tbrNext = constWord.table_branch_reg;
               accNext = constWord.acc;
            end
            OP_TABLE_JUMP:
               pcNext = {pcReg[PC_W-1:TJ_LSB], tbrReg, accReg};
            default: ;
         endcase
      end
   end

   // Architectural state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pcReg    <= PC_RESET;
         accReg   <= '0;
         tbrReg   <= '0;
         carryReg <= 1'b0;
      end
      else
      begin
         pcReg    <= pcNext;
         accReg   <= accNext;
         tbrReg   <= tbrNext;
         carryReg <= carryNext;
      end
   end

   // Software pointer, bank select and sampled memory words
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pointerReg <= '0;
         bankReg    <= 1'b0;
         ramDataReg <= '0;
         romWordReg <= '0;
      end
      else
      begin
         if (wrPtr)
            pointerReg <= ncs_ptr_t'(hwdata[PTR_W-1:0]);
         if (wrBank)
            bankReg <= hwdata[0];
         if (sample)
         begin
            ramDataReg <= ramRdData;
            romWordReg <= romData;
         end
      end
   end

   // Memory side outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         romAddrReg   <= '0;
         ramAddrReg   <= '0;
         ramWrDataReg <= '0;
         ramWeReg     <= 1'b0;
      end
      else
      begin
         romAddrReg   <= romMap(pcReg, bankReg);
         ramAddrReg   <= pointerReg;
         ramWrDataReg <= accReg;
         ramWeReg     <= sample && cmdReg.op == OP_STORE_IND;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdataReg;
   assign romAddr   = romAddrReg;
   assign ramAddr   = ramAddrReg;
   assign ramWrData = ramWrDataReg;
   assign ramWe     = ramWeReg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_instr_four_cycles: assert property ($rose(busyReg) |-> busyReg [*4] ##1 !busyReg)
      else $error("instruction did not last four clocks");
   a_page_bit_hold: assert property (commit && cmdReg.op inside {OP_NOP, OP_ADD, OP_LOAD_IND}
      |=> pcReg == {$past(pcReg[PAGE_BIT]), LOW_W'($past(pcReg[LOW_W-1:0]) + 1'b1)})
      else $error("sequential step changed page or miscounted");
   a_jump_target: assert property (commit && cmdReg.op == OP_UNCOND_JUMP
      |=> pcReg == $past(cmdReg.arg))
      else $error("jump target not loaded");
   a_table_jump: assert property (commit && cmdReg.op == OP_TABLE_JUMP
      |=> pcReg == {$past(pcReg[PC_W-1:TJ_LSB]), $past(tbrReg), $past(accReg)})
      else $error("table jump address wrong");
   a_const_return: assert property (commit && cmdReg.op == OP_RETURN_CONST
      |=> carryReg == $past(carryReg) && accReg == $past(constWord.acc))
      else $error("constant return disturbed carry or value");
   a_int_carry_back: assert property (commit && cmdReg.op == OP_RETURN_INT
      |=> carryReg == $past(stackTop.carry))
      else $error("interrupt return did not restore carry");
   a_add_carry: assert property (commit && cmdReg.op == OP_ADD
      |=> {carryReg, accReg} == {1'b0, $past(accReg)} + {1'b0, $past(ramDataReg)})
      else $error("add result or carry wrong");
   a_int_vector: assert property (commit && cmdReg.op == OP_INT_ENTRY
      |=> pcReg == PC_W'($past(cmdReg.arg[VEC_W-1:0])))
      else $error("interrupt vector wrong");
   a_rom_bank_map: assert property (##1 romAddrReg == $past(romMap(pcReg, bankReg)))
      else $error("ROM bank mapping wrong");
   a_ind_address: assert property (ramWeReg |-> ramAddrReg == $past(pointerReg))
      else $error("indirect write address wrong");

   c_table_jump: cover property (commit && cmdReg.op == OP_TABLE_JUMP);
   c_int_entry: cover property (commit && cmdReg.op == OP_INT_ENTRY);
   c_const_ret: cover property (commit && cmdReg.op == OP_RETURN_CONST);

endmodule : ncs_core
`default_nettype wire

//--- hdl/ncs_pkg.sv
// Shared types and constants for the nibble CPU sequencing datapath
package ncs_pkg;

   // Widths
   localparam int NIB_W    = 4;
   localparam int PC_W     = 12;
   localparam int LOW_W    = 11;
   localparam int PAGE_BIT = 11;
   localparam int TJ_LSB   = 8;
   localparam int ROM_AW   = 13;
   localparam int ROM_DW   = 16;
   localparam int PTR_W    = 10;
   localparam int VEC_W    = 3;
   localparam int DEPTH_W  = 4;
   localparam int STACK_DEPTH = 8;
   localparam int CMD_W    = 20;
   localparam int CONST_W  = 8;
   localparam int BUS_W    = 32;
   localparam int ADDR_W   = 8;

   // Instruction cycle length in oscillator periods
   localparam int OSC_PER_INSTR = 4;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_LAST   = 2'(OSC_PER_INSTR - 1);

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PC     = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PTR    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_BANK   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DATA   = 8'h14;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Reset values and ROM bank prefixes
   localparam logic [PC_W-1:0]    PC_RESET  = 12'h000;
   localparam logic [1:0]         BANK0_HI  = 2'h0;
   localparam logic [1:0]         BANK1_HI  = 2'h1;
   localparam logic [1:0]         BANK2_HI  = 2'h2;
   localparam logic [DEPTH_W-1:0] STACK_FULL = 4'h8;

   // Decimal adjust constants
   localparam logic [NIB_W-1:0] DEC_LIMIT = 4'h9;
   localparam logic [NIB_W-1:0] DEC_ADD   = 4'h6;
   localparam logic [NIB_W-1:0] DEC_SUB   = 4'hA;

   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADI, OP_SBI, OP_DEC_ADJ_ADD,
      OP_DEC_ADJ_SUB, OP_AND, OP_OR, OP_XOR, OP_SHIFT_RIGHT, OP_LOAD_IND,
      OP_STORE_IND, OP_UNCOND_JUMP, OP_BRANCH, OP_CALL, OP_RETURN_INT,
      OP_RETURN_CONST, OP_TABLE_JUMP, OP_INT_ENTRY
   } ncs_op_t;

   typedef enum logic [2:0] {
      COND_A0, COND_A1, COND_A2, COND_A3, COND_AZ, COND_ANZ, COND_C, COND_NC
   } ncs_cond_t;

   typedef struct packed {
      logic [PC_W-1:0] arg;
      ncs_cond_t       cond;
      ncs_op_t         op;
   } ncs_cmd_t;

   typedef struct packed {
      logic            carry;
      logic [PC_W-1:0] pc;
   } ncs_stack_t;

   typedef struct packed {
      logic [DEPTH_W-1:0] depth;
      logic [NIB_W-1:0]   table_branch_reg;
      logic [NIB_W-1:0]   acc;
      logic               carry;
      logic               busy;
   } ncs_status_t;

   typedef struct packed {
      logic [2:0]       high;
      logic [2:0]       mid;
      logic [NIB_W-1:0] low;
   } ncs_ptr_t;

   typedef struct packed {
      logic [NIB_W-1:0] table_branch_reg;
      logic [NIB_W-1:0] acc;
   } ncs_const_t;

   typedef struct packed {
      logic [NIB_W-1:0] value;
      logic             carry;
      logic             carryWr;
      logic             accWr;
   } ncs_alu_t;

endpackage : ncs_pkg

//--- hdl/ncs_stack.sv
// Eight level return stack of carry and program counter
`timescale 1ns/100ps
`default_nettype none
module ncs_stack
   import ncs_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                push,
   input  wire logic                pop,
   input  wire ncs_stack_t          pushEntry,
   output ncs_stack_t               topEntry,
   output logic [DEPTH_W-1:0]       depth
);

   ncs_stack_t mem [STACK_DEPTH];

   // Shift stack: push drops the oldest entry off the bottom silently
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < STACK_DEPTH; i++)
            mem[i] <= '0;
         depth <= '0;
      end
      else if (push)
      begin
         mem[0] <= pushEntry;
         for (int i = 1; i < STACK_DEPTH; i++)
            mem[i] <= mem[i-1];
         depth <= (depth == STACK_FULL) ? depth : depth + 1'b1;
      end
      else if (pop)
      begin
         for (int i = 0; i < STACK_DEPTH - 1; i++)
            mem[i] <= mem[i+1];
         mem[STACK_DEPTH-1] <= '0;
         depth <= (depth == '0) ? depth : depth - 1'b1;
      end
   end

   assign topEntry = mem[0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_push_top: assert property (push |=> topEntry == $past(pushEntry))
      else $error("pushed entry not on top");
   a_pop_order: assert property (pop && !push |=> topEntry == $past(mem[1]))
      else $error("pop did not expose next entry");
   a_depth_cap: assert property (push && depth == STACK_FULL |=> depth == STACK_FULL)
      else $error("stack depth passed eight");
   c_overflow: cover property (push && depth == STACK_FULL);

endmodule : ncs_stack
`default_nettype wire
